// >>> core/mfi_top.sv
// group-two multi-function interrupt flag and enable register
// assumes source request inputs are one-cycle pulses on clock_in and
// that the sequencer pulses svc_ack_in when it takes the group vector
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
module mfi_top (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic timer2_cmp_a_req_in,
  input wire logic timer2_cmp_p_req_in,
  input wire logic timer3_cmp_a_req_in,
  input wire logic timer3_cmp_p_req_in,
  input wire logic ext_periph_req_in,
  input wire logic serial_module_req_in,
  input wire logic svc_ack_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic group_flag_out,
  output logic vec_req_out,
  output logic irq_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] en;
    logic global_en;
    logic timer3;
    logic [3:0] status;
    logic [3:0] mask;
    logic [3:0] snap;
    logic group;
    logic vec;
    logic irq;
  } mfi_top_t;
  mfi_top_t state_ff;
  mfi_top_t nxt_state;

  mfi_bus_if bus ();

  logic [3:0] flags;
  logic [3:0] rise;
  logic [3:0] src_set;
  logic [7:0] reg_view;
  logic wr_group2;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_stat;
  logic cap_stat;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  mfi_avs u_avs (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .bus(bus.slv)
  );

  assign wr_group2 = bus.wr_stb && (bus.addr == mfi_pkg::OFS_GROUP2);
  assign wr_ctrl = bus.wr_stb && (bus.addr == mfi_pkg::OFS_CTRL);
  assign wr_mask = bus.wr_stb && (bus.addr == mfi_pkg::OFS_MASK);
  assign rd_stat = bus.rd_stb && (bus.addr == mfi_pkg::OFS_STAT);
  assign cap_stat = bus.cap && (bus.addr == mfi_pkg::OFS_STAT);

  // ---------------------------------------------------------------
  // source selection and request flags
  // ---------------------------------------------------------------
  // timer module choice
  assign src_set[3] = state_ff.timer3 ? timer3_cmp_a_req_in
                                      : timer2_cmp_a_req_in;
  assign src_set[2] = state_ff.timer3 ? timer3_cmp_p_req_in
                                      : timer2_cmp_p_req_in;
  assign src_set[1] = ext_periph_req_in;
  assign src_set[0] = serial_module_req_in;

  // flag cells, set wins over write
  generate
    for (genvar i = 0; i < mfi_pkg::N_SRC; i++)
    begin : g_flag
      mfi_flag_cell u_cell (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .set_in(src_set[i]),
        .wr_in(wr_group2),
        .wdata_in(bus.wdata[mfi_pkg::FLAG_LSB + i]),
        .q_out(flags[i]),
        .rise_out(rise[i])
      );
    end
  endgenerate

  assign reg_view = {flags, state_ff.en};

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb
  begin
    case (bus.addr)
      mfi_pkg::OFS_GROUP2:
        bus.rdata = {24'h0, reg_view};
      mfi_pkg::OFS_CTRL:
        bus.rdata = {30'h0, state_ff.timer3, state_ff.global_en};
      mfi_pkg::OFS_STAT:
        bus.rdata = {28'h0, state_ff.status};
      mfi_pkg::OFS_MASK:
        bus.rdata = {28'h0, state_ff.mask};
      default:
        bus.rdata = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    // enables written from the low nibble
    if (wr_group2)
      nxt_state.en = bus.wdata[3:0];
    if (wr_mask)
      nxt_state.mask = bus.wdata[3:0];
    // taking the vector drops the global enable to block nesting;
    // a software write in the same cycle still wins
    if (svc_ack_in)
      nxt_state.global_en = 1'b0;
    if (wr_ctrl)
    begin
      nxt_state.global_en = bus.wdata[mfi_pkg::CTRL_GLOBAL_EN];
      nxt_state.timer3 = bus.wdata[mfi_pkg::CTRL_TIMER3];
    end
    // clear only the status bits that the read really returned
    if (cap_stat)
      nxt_state.snap = state_ff.status;
    if (rd_stat)
      nxt_state.status = state_ff.status & ~state_ff.snap;
    nxt_state.status = nxt_state.status | rise;
    // group request, service clears it, new rise wins
    if (svc_ack_in)
      nxt_state.group = 1'b0;
    if (|rise)
      nxt_state.group = 1'b1;
    // vector only with source and global enable
    nxt_state.vec = nxt_state.group & nxt_state.global_en &
                    (|(flags & nxt_state.en));
    nxt_state.irq = |(nxt_state.status & nxt_state.mask);
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_ff.en <= mfi_pkg::RST_GROUP2[3:0];
      state_ff.global_en <= mfi_pkg::RST_CTRL[mfi_pkg::CTRL_GLOBAL_EN];
      state_ff.timer3 <= mfi_pkg::RST_CTRL[mfi_pkg::CTRL_TIMER3];
      state_ff.status <= mfi_pkg::RST_STAT;
      state_ff.mask <= mfi_pkg::RST_MASK;
      state_ff.snap <= 4'h0;
      state_ff.group <= 1'b0;
      state_ff.vec <= 1'b0;
      state_ff.irq <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign group_flag_out = state_ff.group;
  assign vec_req_out = state_ff.vec;
  assign irq_out = state_ff.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  chk_cmp_p_latch: assert property (
    src_set[2] |=> reg_view[mfi_pkg::BIT_CMP_P_REQ])
    else $error("compare P request not latched at bit 6");

  chk_ext_latch: assert property (
    (ext_periph_req_in && !state_ff.en[mfi_pkg::BIT_EXT_EN])
    |=> reg_view[mfi_pkg::BIT_EXT_REQ] ##1 reg_view[mfi_pkg::BIT_EXT_REQ]
        || $past(wr_group2))
    else $error("external request not held at bit 5");

  chk_ser_clear: assert property (
    (wr_group2 && !bus.wdata[mfi_pkg::BIT_SER_REQ] && !serial_module_req_in)
    |=> !reg_view[mfi_pkg::BIT_SER_REQ])
    else $error("serial flag not cleared by software write");

  chk_p_en_write: assert property (
    wr_group2 |=> state_ff.en[mfi_pkg::BIT_CMP_P_EN] ==
                $past(bus.wdata[mfi_pkg::BIT_CMP_P_EN]))
    else $error("compare P enable not written");

  chk_ext_en_hold: assert property (
    !wr_group2 |=> $stable(state_ff.en[mfi_pkg::BIT_EXT_EN]))
    else $error("external enable changed without a write");

  chk_ser_en_read: assert property (
    (bus.cap && bus.addr == mfi_pkg::OFS_GROUP2)
    |=> avs_readdata_out[mfi_pkg::BIT_SER_EN] == $past(state_ff.en[0]))
    else $error("serial enable read back wrong");

  chk_reset_zero: assert property (
    @(posedge clock_in) disable iff (1'b0)
    rst_in |=> reg_view == mfi_pkg::RST_GROUP2)
    else $error("register not zero after reset");

  chk_timer3_sel: assert property (
    (state_ff.timer3 && timer3_cmp_a_req_in)
    |=> reg_view[mfi_pkg::BIT_CMP_A_REQ])
    else $error("third timer compare A not routed");

  chk_group_set: assert property (
    (|rise) |=> group_flag_out ##1 1)
    else $error("group request not set by a new flag");

  chk_group_svc: assert property (
    (svc_ack_in && !(|rise)) |=> !group_flag_out && $stable(flags) ||
    $past(|src_set) || $past(wr_group2))
    else $error("service did not clear only the group flag");

  chk_vec_gate: assert property (
    vec_req_out |-> $past(nxt_state.global_en) &&
                    (|($past(flags) & state_ff.en)))
    else $error("vector raised without enables");

  // each bit of the register is pinned to its own duty below
  chk_p_req_write: assert property (
    (wr_group2 && bus.wdata[mfi_pkg::BIT_CMP_P_REQ])
    |=> reg_view[mfi_pkg::BIT_CMP_P_REQ])
    else $error("compare P flag not set by software write");

  chk_ext_clear: assert property (
    (wr_group2 && !bus.wdata[mfi_pkg::BIT_EXT_REQ] && !ext_periph_req_in)
    |=> !reg_view[mfi_pkg::BIT_EXT_REQ])
    else $error("external flag not cleared by software write");

  chk_ser_latch: assert property (
    serial_module_req_in |=> reg_view[mfi_pkg::BIT_SER_REQ])
    else $error("serial request not latched at bit 4");

  chk_p_en_hold: assert property (
    !wr_group2 |=> $stable(state_ff.en[mfi_pkg::BIT_CMP_P_EN]))
    else $error("compare P enable changed without a write");

  chk_ext_en_write: assert property (
    wr_group2 |=> state_ff.en[mfi_pkg::BIT_EXT_EN] ==
                  $past(bus.wdata[mfi_pkg::BIT_EXT_EN]))
    else $error("external enable not written");

  chk_ser_en_write: assert property (
    wr_group2 |=> state_ff.en[mfi_pkg::BIT_SER_EN] ==
                  $past(bus.wdata[mfi_pkg::BIT_SER_EN]))
    else $error("serial enable not written");

  chk_ser_en_hold: assert property (
    !wr_group2 |=> $stable(state_ff.en[mfi_pkg::BIT_SER_EN]))
    else $error("serial enable changed without a write");

  chk_a_en_write: assert property (
    wr_group2 |=> state_ff.en[mfi_pkg::BIT_CMP_A_EN] ==
                  $past(bus.wdata[mfi_pkg::BIT_CMP_A_EN]))
    else $error("compare A enable not written");

  chk_cmp_a_latch: assert property (
    src_set[3] |=> reg_view[mfi_pkg::BIT_CMP_A_REQ])
    else $error("compare A request not latched at bit 7");

  chk_timer2_sel: assert property (
    (!state_ff.timer3 && timer2_cmp_p_req_in)
    |=> reg_view[mfi_pkg::BIT_CMP_P_REQ])
    else $error("second timer compare P not routed");

  chk_group_hold: assert property (
    (group_flag_out && !svc_ack_in) |=> group_flag_out)
    else $error("group request dropped without service");

  chk_svc_flags_kept: assert property (
    (svc_ack_in && !wr_group2)
    |=> (flags & $past(flags)) == $past(flags))
    else $error("service cleared a source flag");

  chk_vec_global: assert property (
    !state_ff.global_en |-> !vec_req_out)
    else $error("vector raised with global enable off");

  chk_vec_group: assert property (
    vec_req_out |-> group_flag_out)
    else $error("vector raised without a group request");
endmodule

// >>> include/mfi_pkg.sv
// constants, field layout and bus states of the group-two interrupt block
// assumes a single 40 MHz clock and an Avalon-MM register slave
//
// What this block does
// - bit 6 holds the timer compare P request flag, software read and write
// - bit 5 holds the external peripheral request flag
// - bit 4 holds the serial module request flag, software writable
// - bit 2 enables the timer compare P interrupt
// - bit 1 enables the external peripheral interrupt
// - bit 0 enables the serial module interrupt
// - any newly set flag sets the group request; service clears it and the global enable, never a flag
// - flags latch even when disabled; vector needs enable and global enable
package mfi_pkg;
  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int N_SRC = 4;
  localparam logic [3:0] OFS_GROUP2 = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_MASK = 4'hc;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_CMP_A_REQ = 7;
  localparam int BIT_CMP_P_REQ = 6;
  localparam int BIT_EXT_REQ = 5;
  localparam int BIT_SER_REQ = 4;
  localparam int BIT_CMP_A_EN = 3;
  localparam int BIT_CMP_P_EN = 2;
  localparam int BIT_EXT_EN = 1;
  localparam int BIT_SER_EN = 0;
  localparam int FLAG_LSB = 4;
  localparam int CTRL_GLOBAL_EN = 0;
  localparam int CTRL_TIMER3 = 1;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_GROUP2 = 8'h00;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [3:0] RST_STAT = 4'h0;
  localparam logic [3:0] RST_MASK = 4'h0;
  typedef enum logic {
    MFI_BUS_IDLE = 1'b0,
    MFI_BUS_ANSWER = 1'b1
  } mfi_bus_state_t;
endpackage

// >>> include/mfi_bus_if.sv
// commit strobes between the bus slave and the register logic
// assumes both ends sit on clock_in
interface mfi_bus_if;
  logic wr_stb;
  logic rd_stb;
  logic cap;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [31:0] rdata;
  modport slv (
    output wr_stb,
    output rd_stb,
    output cap,
    output addr,
    output wdata,
    input rdata
  );
  modport regs (
    input wr_stb,
    input rd_stb,
    input cap,
    input addr,
    input wdata,
    output rdata
  );
endinterface

// >>> core/mfi_flag_cell.sv
// one request flag: hardware set, software read and write
// assumes set_in and wr_in are synchronous to clock_in
module mfi_flag_cell (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic set_in,
  input wire logic wr_in,
  input wire logic wdata_in,
  output logic q_out,
  output logic rise_out
);
  typedef struct packed {
    logic q;
    logic rise;
  } mfi_cell_t;
  mfi_cell_t state_ff;
  mfi_cell_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    if (wr_in)
      nxt_state.q = wdata_in;
    // set wins over a software clear in the same cycle
    if (set_in)
      nxt_state.q = 1'b1;
    nxt_state.rise = nxt_state.q & ~state_ff.q;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign q_out = state_ff.q;
  assign rise_out = state_ff.rise;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  chk_cell_set_wins: assert property (set_in |=> q_out)
    else $error("flag lost a hardware set");
endmodule

// >>> core/mfi_avs.sv
// Avalon-MM slave: one wait cycle, then commit at the answering edge
// assumes the master holds its request until waitrequest is seen low
module mfi_avs (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  mfi_bus_if.slv bus
);
  typedef struct packed {
    mfi_pkg::mfi_bus_state_t st;
    logic wait_req;
    logic [31:0] rdata;
  } mfi_avs_t;
  mfi_avs_t state_ff;
  mfi_avs_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    bus.addr = avs_address_in;
    bus.wdata = avs_writedata_in[7:0];
    bus.cap = 1'b0;
    bus.wr_stb = 1'b0;
    bus.rd_stb = 1'b0;
    case (state_ff.st)
      mfi_pkg::MFI_BUS_IDLE:
      begin
        if (avs_read_in || avs_write_in)
        begin
          // read data is captured here so it stands at the answer edge
          bus.cap = avs_read_in;
          nxt_state.rdata = avs_read_in ? bus.rdata : 32'h0;
          nxt_state.st = mfi_pkg::MFI_BUS_ANSWER;
        end
      end
      mfi_pkg::MFI_BUS_ANSWER:
      begin
        bus.wr_stb = avs_write_in & avs_byteenable_in[0];
        bus.rd_stb = avs_read_in;
        nxt_state.st = mfi_pkg::MFI_BUS_IDLE;
      end
      default:
        nxt_state.st = mfi_pkg::MFI_BUS_IDLE;
    endcase
    nxt_state.wait_req = (nxt_state.st == mfi_pkg::MFI_BUS_IDLE);
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      state_ff <= {mfi_pkg::MFI_BUS_IDLE, 1'b1, 32'h0};
    else
      state_ff <= nxt_state;
  end

  assign avs_readdata_out = state_ff.rdata;
  assign avs_waitrequest_out = state_ff.wait_req;
endmodule

// >>> dv/mfi_src_model.sv
// far-side model: the four peripheral sources and the interrupt sequencer
// assumes bench commands change just after a rising edge of clock_in
module mfi_src_model (
  input wire logic clock_in,
  input wire logic [5:0] fire_in,
  input wire logic ack_on_in,
  input wire logic [3:0] ack_dly_in,
  input wire logic vec_req_in,
  output logic [5:0] req_out,
  output logic svc_ack_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_ff;
  initial
  begin
    req_out = 6'h00;
    svc_ack_out = 1'b0;
    cnt_ff = 4'h0;
  end
  // ---------------------------------------------------------------
  // sources and sequencer
  // ---------------------------------------------------------------
  // one-cycle pulses, so each event sets its flag exactly once
  always @(posedge clock_in)
  begin
    req_out <= fire_in;
    svc_ack_out <= 1'b0;
    if (ack_on_in && vec_req_in && !svc_ack_out)
    begin
      if (cnt_ff == ack_dly_in)
      begin
        svc_ack_out <= 1'b1;
        cnt_ff <= 4'h0;
      end
      else
        cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule

// >>> dv/tb.sv
// self-checking bench for the group-two interrupt flag register
// assumes the partner model drives the sources and the service acknowledge
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in, rst_in, avs_read, avs_write, ack_on;
  logic [3:0] avs_address, avs_be, ack_dly;
  logic [31:0] avs_wdata, rdata;
  logic [31:0] avs_readdata;
  logic avs_wait, group_flag, vec_req, irq;
  logic [5:0] fire, req;
  logic svc_ack;
  int n_errors, tests_run;
  mfi_top i_dut (
    .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(avs_address),
    .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_wdata), .avs_byteenable_in(avs_be),
    .timer2_cmp_a_req_in(req[5]), .timer2_cmp_p_req_in(req[4]),
    .timer3_cmp_a_req_in(req[3]), .timer3_cmp_p_req_in(req[2]),
    .ext_periph_req_in(req[1]), .serial_module_req_in(req[0]),
    .svc_ack_in(svc_ack), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_wait), .group_flag_out(group_flag),
    .vec_req_out(vec_req), .irq_out(irq)
  );
  mfi_src_model i_src (
    .clock_in(clock_in), .fire_in(fire), .ack_on_in(ack_on),
    .ack_dly_in(ack_dly), .vec_req_in(vec_req), .req_out(req),
    .svc_ack_out(svc_ack)
  );
  always #12.5 clock_in = ~clock_in;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic we, input logic [3:0] a,
                     input logic [31:0] wd, input logic [3:0] be);
    @(posedge clock_in);
    avs_address <= a;
    avs_wdata <= wd;
    avs_be <= be;
    avs_read <= !we;
    avs_write <= we;
    do @(posedge clock_in); while (avs_wait !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a,
                        input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(what, rdata, exp);
  endtask
  task automatic fire_src(input logic [5:0] b);
    @(posedge clock_in);
    fire <= b;
    @(posedge clock_in);
    fire <= 6'h00;
    repeat (4) @(posedge clock_in);
    @(negedge clock_in);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
      rd_chk("reset value", 4'(i * 4), 32'h0);
    rd_chk("unmapped read", 4'h2, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_rw;
    bus(1'b1, mfi_pkg::OFS_GROUP2, 32'h0f, 4'hf);
    rd_chk("enable bits", mfi_pkg::OFS_GROUP2, 32'h0f);
    bus(1'b1, mfi_pkg::OFS_GROUP2, 32'hff, 4'h0);
    rd_chk("byte disabled", mfi_pkg::OFS_GROUP2, 32'h0f);
    bus(1'b1, 4'h2, 32'hff, 4'hf);
    rd_chk("unmapped write", mfi_pkg::OFS_GROUP2, 32'h0f);
    bus(1'b1, mfi_pkg::OFS_GROUP2, 32'hf5, 4'hf);
    rd_chk("flags written", mfi_pkg::OFS_GROUP2, 32'hf5);
    rd_chk("status set", mfi_pkg::OFS_STAT, 32'h0f);
    rd_chk("status cleared", mfi_pkg::OFS_STAT, 32'h0);
    bus(1'b1, mfi_pkg::OFS_GROUP2, 32'h00, 4'hf);
    rd_chk("flags cleared", mfi_pkg::OFS_GROUP2, 32'h0);
    $display("test read_write done");
  endtask
  // every source with both timer selections, all enables off
  task automatic t_src;
    logic [7:0] exp;
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 6; i++)
      begin
        exp = (i > 3) ? (8'h10 << (5 - i)) : ((i / 2 == s) ?
              (8'h40 << (1 - i % 2)) : 8'h00);
        bus(1'b1, mfi_pkg::OFS_CTRL, 32'(s * 2), 4'hf);
        fire_src(6'h20 >> i);
        rd_chk("source flag", mfi_pkg::OFS_GROUP2, 32'(exp));
        rd_chk("source status", mfi_pkg::OFS_STAT, 32'(exp >> 4));
        bus(1'b1, mfi_pkg::OFS_GROUP2, 32'h00, 4'hf);
      end
    bus(1'b1, mfi_pkg::OFS_CTRL, 32'h0, 4'hf);
    $display("test sources done");
  endtask
  task automatic t_irq;
    bus(1'b1, mfi_pkg::OFS_MASK, 32'h2, 4'hf);
    rd_chk("mask value", mfi_pkg::OFS_MASK, 32'h2);
    fire_src(6'h01);
    chk("masked irq", irq, 1'b0);
    fire_src(6'h02);
    chk("unmasked irq", irq, 1'b1);
    rd_chk("irq status", mfi_pkg::OFS_STAT, 32'h3);
    repeat (3) @(negedge clock_in);
    chk("irq after read", irq, 1'b0);
    bus(1'b1, mfi_pkg::OFS_GROUP2, 32'h00, 4'hf);
    bus(1'b1, mfi_pkg::OFS_MASK, 32'h0, 4'hf);
    $display("test interrupt done");
  endtask
  // slow service: vector seen first, then the group flag and global enable clear, the source flag is kept
  task automatic t_vec;
    ack_on <= 1'b1;
    ack_dly <= 4'h8;
    bus(1'b1, mfi_pkg::OFS_GROUP2, 32'h02, 4'hf);
    bus(1'b1, mfi_pkg::OFS_CTRL, 32'h1, 4'hf);
    fire_src(6'h02);
    chk("vector raised", vec_req, 1'b1);
    chk("group raised", group_flag, 1'b1);
    repeat (14) @(negedge clock_in);
    chk("group serviced", group_flag, 1'b0);
    rd_chk("flag kept", mfi_pkg::OFS_GROUP2, 32'h22);
    rd_chk("global cleared", mfi_pkg::OFS_CTRL, 32'h0);
    bus(1'b1, mfi_pkg::OFS_GROUP2, 32'h02, 4'hf);
    bus(1'b1, mfi_pkg::OFS_CTRL, 32'h1, 4'hf);
    fire_src(6'h01);
    chk("disabled group", group_flag, 1'b1);
    chk("disabled vector", vec_req, 1'b0);
    ack_on <= 1'b0;
    bus(1'b1, mfi_pkg::OFS_GROUP2, 32'h00, 4'hf);
    $display("test vector done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    clock_in = 1'b0;
    rst_in = 1'b1;
    {avs_read, avs_write, ack_on} = 3'h0;
    {avs_address, avs_be, ack_dly} = 12'h000;
    avs_wdata = 32'h0;
    fire = 6'h00;
    n_errors = 0;
    tests_run = 0;
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset();
    t_rw();
    t_src();
    t_irq();
    t_vec();
    final_report();
  end
  // the tests need about 360 cycles
  initial
  begin
    repeat (6000) @(posedge clock_in);
    n_errors++;
    final_report();
  end
endmodule
